// *** rtl/scrc_pkg.sv ***
// scrc_pkg: constants, types and encodings for the system control block
// assumes a 200 MHz system clock and a JTAG clock sampled by it
package scrc_pkg;
   localparam int SCRC_IR_W = 6;
   localparam int SCRC_DR_W = 64;
   localparam int SCRC_TIME_W = 15;
   localparam int SCRC_FREQ_W = 8;
   // instruction codes
   localparam logic [5:0] SCRC_I_FAST_PLL = 6'h01;
   localparam logic [5:0] SCRC_I_LIB_PLL = 6'h02;
   localparam logic [5:0] SCRC_I_TIME_CFG = 6'h03;
   localparam logic [5:0] SCRC_I_LINK_INIT = 6'h04;
   localparam logic [5:0] SCRC_I_ARQ_RST = 6'h05;
   localparam logic [5:0] SCRC_I_STATUS = 6'h10;
   localparam logic [5:0] SCRC_I_PAY_WR = 6'h11;
   localparam logic [5:0] SCRC_I_PAY_RD = 6'h12;
   localparam logic [5:0] SCRC_I_BYPASS = 6'h3F;
   // shift lengths minus one, then the ir capture pattern
   localparam logic [5:0] SCRC_L_FAST = 6'h01;
   localparam logic [5:0] SCRC_L_LIB = 6'h08;
   localparam logic [5:0] SCRC_L_TIME = 6'h0E;
   localparam logic [5:0] SCRC_L_LINK = 6'h00;
   localparam logic [5:0] SCRC_L_ARQ = 6'h03;
   localparam logic [5:0] SCRC_L_STAT = 6'h1F;
   localparam logic [5:0] SCRC_L_PAY = 6'h3F;
   localparam logic [5:0] SCRC_L_BYP = 6'h00;
   localparam logic [5:0] SCRC_IR_CAPT = 6'h01;
   // defaults after test logic reset
   localparam logic [7:0] SCRC_LIB_FREQ_RST = 8'h64;
   // apb map, then the last count of the core divider
   localparam logic [11:0] SCRC_A_TIME = 12'h000;
   localparam logic [11:0] SCRC_A_PLL = 12'h004;
   localparam logic [11:0] SCRC_A_CTRL = 12'h008;
   localparam logic [11:0] SCRC_A_STAT = 12'h00C;
   localparam logic [1:0] SCRC_DIV4_LAST = 2'h3;
   typedef struct packed {
      logic fast_en;
      logic fast_hs;
      logic lib_en;
      logic [SCRC_FREQ_W-1:0] lib_freq;
   } scrc_pll_cfg_s;
   typedef struct packed {
      logic [7:0] crc_err;
      logic [7:0] timeout;
      logic [15:0] misc;
   } scrc_status_s;
   typedef enum logic [15:0] {
      SCRC_TLR = 16'h0001, SCRC_IDLE = 16'h0002, SCRC_SEL_DR = 16'h0004, SCRC_CAP_DR = 16'h0008,
      SCRC_SH_DR = 16'h0010, SCRC_EX1_DR = 16'h0020, SCRC_PA_DR = 16'h0040, SCRC_EX2_DR = 16'h0080,
      SCRC_UP_DR = 16'h0100, SCRC_SEL_IR = 16'h0200, SCRC_CAP_IR = 16'h0400, SCRC_SH_IR = 16'h0800,
      SCRC_EX1_IR = 16'h1000, SCRC_PA_IR = 16'h2000, SCRC_EX2_IR = 16'h4000, SCRC_UP_IR = 16'h8000
   } scrc_tap_e;
endpackage

// *** rtl/scrc_top.sv ***
// scrc_top: jtag tap, pll control, system time counter, apb status port
// assumes jtag pins arrive asynchronously; tms doubles as the start toggle
`timescale 1ns/1ps
module scrc_top
   import scrc_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // jtag pins
   input wire logic tck_in,
   input wire logic tms_in,
   input wire logic tdi_in,
   output logic tdo_out,
   output logic tdo_oe_out,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // clock and link control
   output scrc_pll_cfg_s pll_cfg_out,
   output logic link_en_out,
   output logic [3:0] arq_rst_out,
   output logic core_clk_en_out,
   output logic [SCRC_TIME_W-1:0] sys_time_out,
   // payload ports and status from communication logic
   output logic [SCRC_DR_W-1:0] pay_wr_data_out,
   output logic pay_wr_valid_out,
   input wire logic pay_wr_ready_in,
   input wire logic [SCRC_DR_W-1:0] pay_rd_data_in,
   input wire scrc_status_s status_in
);
   function automatic logic [5:0] dr_last(input logic [5:0] ir);
      unique case (ir)
         SCRC_I_FAST_PLL: dr_last = SCRC_L_FAST;
         SCRC_I_LIB_PLL: dr_last = SCRC_L_LIB;
         SCRC_I_TIME_CFG: dr_last = SCRC_L_TIME;
         SCRC_I_LINK_INIT: dr_last = SCRC_L_LINK;
         SCRC_I_ARQ_RST: dr_last = SCRC_L_ARQ;
         SCRC_I_STATUS: dr_last = SCRC_L_STAT;
         SCRC_I_PAY_WR, SCRC_I_PAY_RD: dr_last = SCRC_L_PAY;
         default: dr_last = SCRC_L_BYP;
      endcase
   endfunction

   logic [2:0] s1_q, s2_q;
   logic tck_prev_q;
   logic tms_prev_q;
   wire logic tck_s = s2_q[0];
   wire logic tms_s = s2_q[1];
   wire logic tdi_s = s2_q[2];
   wire logic tck_rise = tck_s & ~tck_prev_q;
   wire logic tck_fall = ~tck_s & tck_prev_q;

   // two-flop synchronisers for the jtag pins
   always_ff @(posedge clk_in) begin
      s1_q <= {tdi_in, tms_in, tck_in};
      s2_q <= s1_q;
      tck_prev_q <= tck_s;
      tms_prev_q <= tms_s;
   end

   scrc_tap_e tap_q, tap_d;
   always_comb begin
      unique case (tap_q)
         SCRC_TLR: tap_d = tms_s ? SCRC_TLR : SCRC_IDLE;
         SCRC_IDLE: tap_d = tms_s ? SCRC_SEL_DR : SCRC_IDLE;
         SCRC_SEL_DR: tap_d = tms_s ? SCRC_SEL_IR : SCRC_CAP_DR;
         SCRC_CAP_DR: tap_d = tms_s ? SCRC_EX1_DR : SCRC_SH_DR;
         SCRC_SH_DR: tap_d = tms_s ? SCRC_EX1_DR : SCRC_SH_DR;
         SCRC_EX1_DR: tap_d = tms_s ? SCRC_UP_DR : SCRC_PA_DR;
         SCRC_PA_DR: tap_d = tms_s ? SCRC_EX2_DR : SCRC_PA_DR;
         SCRC_EX2_DR: tap_d = tms_s ? SCRC_UP_DR : SCRC_SH_DR;
         SCRC_UP_DR: tap_d = tms_s ? SCRC_SEL_DR : SCRC_IDLE;
         SCRC_SEL_IR: tap_d = tms_s ? SCRC_TLR : SCRC_CAP_IR;
         SCRC_CAP_IR: tap_d = tms_s ? SCRC_EX1_IR : SCRC_SH_IR;
         SCRC_SH_IR: tap_d = tms_s ? SCRC_EX1_IR : SCRC_SH_IR;
         SCRC_EX1_IR: tap_d = tms_s ? SCRC_UP_IR : SCRC_PA_IR;
         SCRC_PA_IR: tap_d = tms_s ? SCRC_EX2_IR : SCRC_PA_IR;
         SCRC_EX2_IR: tap_d = tms_s ? SCRC_UP_IR : SCRC_SH_IR;
         SCRC_UP_IR: tap_d = tms_s ? SCRC_SEL_DR : SCRC_IDLE;
         default: tap_d = SCRC_TLR;
      endcase
   end

   // tap state advances on each sampled tck rise
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tap_q <= SCRC_TLR;
      end else if (tck_rise) begin
         tap_q <= tap_d;
      end
   end

   logic [SCRC_IR_W-1:0] ir_q, ir_sh_q;
   logic [SCRC_DR_W-1:0] dr_q;
   wire logic [5:0] len = dr_last(ir_q);

   // instruction register
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || tap_q == SCRC_TLR) begin
         ir_q <= SCRC_I_BYPASS;
         ir_sh_q <= SCRC_IR_CAPT;
      end else if (tck_rise) begin
         if (tap_q == SCRC_CAP_IR) begin
            ir_sh_q <= SCRC_IR_CAPT;
         end else if (tap_q == SCRC_SH_IR) begin
            ir_sh_q <= {tdi_s, ir_sh_q[SCRC_IR_W-1:1]};
         end else if (tap_q == SCRC_UP_IR) begin
            ir_q <= ir_sh_q;
         end
      end
   end

   // data shift register, not cleared by reset
   always_ff @(posedge clk_in) begin
      if (tck_rise && tap_q == SCRC_CAP_DR) begin
         unique case (ir_q)
            SCRC_I_STATUS: dr_q <= {32'h0000_0000, status_in};
            SCRC_I_PAY_RD: dr_q <= pay_rd_data_in;
            SCRC_I_LIB_PLL: dr_q <= {55'h0, pll_cfg_out.lib_en, pll_cfg_out.lib_freq};
            default: dr_q <= dr_q;
         endcase
      end else if (tck_rise && tap_q == SCRC_SH_DR) begin
         dr_q <= dr_q >> 1;
         dr_q[len] <= tdi_s;
      end
   end

   // tdo changes on falling tck, enabled while shifting
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         tdo_out <= 1'b0;
         tdo_oe_out <= 1'b0;
      end else if (tck_fall) begin
         tdo_out <= (tap_q == SCRC_SH_IR) ? ir_sh_q[0] : dr_q[0];
         tdo_oe_out <= (tap_q == SCRC_SH_IR) || (tap_q == SCRC_SH_DR);
      end
   end

   wire logic upd = tck_rise && tap_q == SCRC_UP_DR;
   logic link_init_q;
   logic link_hold_q;
   logic arm_q, run_q;
   logic [SCRC_TIME_W-1:0] time_q;

   // control registers, defaults on test logic reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || tap_q == SCRC_TLR) begin
         pll_cfg_out <= '{fast_en: 1'b1, fast_hs: 1'b0, lib_en: 1'b1, lib_freq: SCRC_LIB_FREQ_RST};
         link_init_q <= 1'b0;
      end else if (upd) begin
         unique case (ir_q)
            SCRC_I_FAST_PLL: {pll_cfg_out.fast_hs, pll_cfg_out.fast_en} <= dr_q[1:0];
            SCRC_I_LIB_PLL: {pll_cfg_out.lib_en, pll_cfg_out.lib_freq} <= dr_q[8:0];
            SCRC_I_LINK_INIT: link_init_q <= dr_q[0];
            default: link_init_q <= link_init_q;
         endcase
      end
   end

   // arq resets are one-cycle pulses per instance
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         arq_rst_out <= 4'h0;
      end else begin
         arq_rst_out <= (upd && ir_q == SCRC_I_ARQ_RST) ? dr_q[3:0] : 4'h0;
      end
   end

   // payload injection holds until the port accepts it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pay_wr_valid_out <= 1'b0;
      end else if (upd && ir_q == SCRC_I_PAY_WR) begin
         pay_wr_valid_out <= 1'b1;
         pay_wr_data_out <= dr_q;
      end else if (pay_wr_ready_in) begin
         pay_wr_valid_out <= 1'b0;
      end
   end

   // system time counter: cleared and armed by reset, started by tms toggle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         time_q <= '0;
         arm_q <= 1'b1;
         run_q <= 1'b0;
      end else begin
         if (arm_q && tms_s != tms_prev_q) begin
            arm_q <= 1'b0;
            run_q <= 1'b1;
         end
         if (upd && ir_q == SCRC_I_TIME_CFG) begin
            time_q <= dr_q[SCRC_TIME_W-1:0];
         end else if (run_q) begin
            time_q <= time_q + 1'b1;
         end
      end
   end

   logic [1:0] div_q;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         div_q <= 2'h0;
         core_clk_en_out <= 1'b0;
         sys_time_out <= '0;
         link_en_out <= 1'b0;
      end else begin
         div_q <= div_q + 1'b1;
         core_clk_en_out <= (div_q == SCRC_DIV4_LAST);
         sys_time_out <= time_q;
         link_en_out <= link_init_q & ~link_hold_q;
      end
   end

   // apb slave, one wait-free access cycle
   wire logic apb_setup = psel_in & ~penable_in;
   wire logic apb_wr = psel_in & penable_in & pwrite_in & pready_out;
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         link_hold_q <= 1'b0;
      end else begin
         pready_out <= apb_setup;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         if (apb_setup) begin
            unique case (paddr_in)
               SCRC_A_TIME: prdata_out <= {15'h0, run_q, arm_q, time_q};
               SCRC_A_PLL: prdata_out <= {21'h0, pll_cfg_out};
               SCRC_A_CTRL: prdata_out <= {30'h0, link_init_q, link_hold_q};
               SCRC_A_STAT: prdata_out <= status_in;
               default: pslverr_out <= 1'b1;
            endcase
         end
         if (apb_wr && paddr_in == SCRC_A_CTRL) begin
            link_hold_q <= pwdata_in[0];
         end
      end
   end

   // checks
   property p_tlr_defaults;
      @(posedge clk_in) disable iff (!rst_n_in)
      tap_q == SCRC_TLR |=> pll_cfg_out.lib_freq == SCRC_LIB_FREQ_RST && !link_init_q;
   endproperty
   a_tlr_defaults: assert property (p_tlr_defaults) else $error("tlr defaults missing");
   property p_link_off;
      @(posedge clk_in) disable iff (!rst_n_in)
      tap_q == SCRC_TLR ##1 tap_q == SCRC_TLR |=> !link_en_out;
   endproperty
   a_link_off: assert property (p_link_off) else $error("link on in test reset");
   property p_reset_time;
      @(posedge clk_in) !rst_n_in |=> time_q == '0 && arm_q && !run_q && tap_q == SCRC_TLR;
   endproperty
   a_reset_time: assert property (p_reset_time) else $error("reset did not arm counter");
   property p_no_start;
      @(posedge clk_in) disable iff (!rst_n_in)
      arm_q && tms_s == tms_prev_q |=> !run_q;
   endproperty
   a_no_start: assert property (p_no_start) else $error("counter started without toggle");
   property p_count;
      @(posedge clk_in) disable iff (!rst_n_in)
      run_q && !upd |=> time_q == SCRC_TIME_W'($past(time_q) + 1'b1);
   endproperty
   a_count: assert property (p_count) else $error("time counter step wrong");
   property p_ir_update;
      @(posedge clk_in) disable iff (!rst_n_in)
      tck_rise && tap_q == SCRC_UP_IR |=> ir_q == $past(ir_sh_q);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("ir not loaded");
   property p_fast_pll;
      @(posedge clk_in) disable iff (!rst_n_in)
      upd && ir_q == SCRC_I_FAST_PLL |=> pll_cfg_out.fast_hs == $past(dr_q[1]);
   endproperty
   a_fast_pll: assert property (p_fast_pll) else $error("link speed not set");
   property p_arq_pulse;
      @(posedge clk_in) disable iff (!rst_n_in)
      arq_rst_out != 4'h0 |=> arq_rst_out == 4'h0;
   endproperty
   a_arq_pulse: assert property (p_arq_pulse) else $error("arq reset not a pulse");
   property p_div4;
      @(posedge clk_in) disable iff (!rst_n_in)
      core_clk_en_out |=> !core_clk_en_out ##1 !core_clk_en_out ##1 !core_clk_en_out ##1 core_clk_en_out;
   endproperty
   a_div4: assert property (p_div4) else $error("core enable not one in four");
   property p_status_cap;
      @(posedge clk_in) disable iff (!rst_n_in)
      tck_rise && tap_q == SCRC_CAP_DR && ir_q == SCRC_I_STATUS |=> dr_q[31:0] == $past(status_in);
   endproperty
   a_status_cap: assert property (p_status_cap) else $error("status not captured");
   c_start: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(run_q));
   c_inject: cover property (@(posedge clk_in) disable iff (!rst_n_in) pay_wr_valid_out && pay_wr_ready_in);
   c_wrap: cover property (@(posedge clk_in) disable iff (!rst_n_in) run_q && time_q == '1);
endmodule

// *** tb/scrc_jtag_host.sv ***
// scrc_jtag_host: jtag test controller model on the tap pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module scrc_jtag_host (
   // jtag pins
   output logic tck_out,
   output logic tms_out,
   output logic tdi_out,
   input wire logic tdo_in
);
   // tck stands still between frames, tms high keeps the tap reset
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b0;
   end
   // one 125 ns tck period, tdo taken at the rise
   task automatic tick(input logic m, input logic d, output logic q);
      tms_out <= m;
      tdi_out <= d;
      #62.5 tck_out <= 1'b1;
      q = tdo_in;
      #62.5 tck_out <= 1'b0;
   endtask
   // idle, capture, shift lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [63:0] d, output logic [63:0] q);
      logic b;
      q = '0;
      tick(1'b1, ~tdi_out, b);
      if (ir) begin
         tick(1'b1, ~tdi_out, b);
      end
      tick(1'b0, ~tdi_out, b);
      tick(1'b0, ~tdi_out, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, d[i], b);
         q[i] = b;
      end
      tick(1'b1, ~tdi_out, b);
      tick(1'b0, ~tdi_out, b);
   endtask
endmodule

// *** tb/scrc_top_tb_top.sv ***
// scrc_top_tb_top: self-checking bench for the system control block
// assumes scrc_pkg, scrc_top and scrc_jtag_host compiled first
`timescale 1ns/1ps
module scrc_top_tb_top
   import scrc_pkg::*;
();
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, pready, pslverr, link_en, pay_valid, core_en, e;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   scrc_pll_cfg_s pll_cfg;
   logic [3:0] arq, seen;
   logic [14:0] sys_time, t0;
   logic [63:0] pay_wr, q;
   logic pay_ready = 1'b0;
   logic [63:0] pay_rd = 64'h0123_4567_89AB_CDEF;
   scrc_status_s status = 32'h5A3C_0F81;
   int fail_count = 0;
   int total_checks = 0;
   int n;
   always #2.5 clk = ~clk;
   scrc_top scrc_top_inst (.clk_in(clk), .rst_n_in(rst_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_oe_out(tdo_oe), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .pll_cfg_out(pll_cfg), .link_en_out(link_en), .arq_rst_out(arq),
      .core_clk_en_out(core_en), .sys_time_out(sys_time), .pay_wr_data_out(pay_wr),
      .pay_wr_valid_out(pay_valid), .pay_wr_ready_in(pay_ready), .pay_rd_data_in(pay_rd),
      .status_in(status));
   scrc_jtag_host scrc_jtag_host_inst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo));
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk);
      end
      if (k >= 20) begin
         fail_count++;
         $display("[ERR] %0t apb no answer", $time);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ir(input logic [5:0] c);
      scrc_jtag_host_inst.scan(1'b1, 6, {58'h0, c}, q);
      chk(q[5:0] === SCRC_IR_CAPT, "ir capture");
   endtask
   task automatic dr(input int len, input logic [63:0] d);
      scrc_jtag_host_inst.scan(1'b0, len, d, q);
   endtask
   task automatic t_reset();
      n = 0;
      repeat (40) begin
         @(posedge clk);
         n += core_en;
      end
      chk(n == 10, "core enable rate");
      chk(sys_time === 15'h0000, "counter ran early");
      chk(pll_cfg === 11'h564, "pll reset value");
      apb(1'b0, SCRC_A_TIME, 32'h0);
      chk(r[16:15] === 2'b01, "not armed");
      $display("reset test done");
   endtask
   task automatic t_start();
      scrc_jtag_host_inst.tick(1'b0, 1'b0, e);
      @(posedge clk);
      t0 = sys_time;
      repeat (10) @(posedge clk);
      chk(sys_time - t0 === 15'h00A, "count rate");
      ir(SCRC_I_TIME_CFG);
      dr(15, 64'h7F00);
      n = 0;
      while (sys_time !== 15'h7FFF && n < 400) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      chk(sys_time === 15'h0000, "wrap");
      $display("start test done");
   endtask
   task automatic t_pll();
      ir(SCRC_I_LIB_PLL);
      dr(9, 64'h1C8);
      chk(pll_cfg[8:0] === 9'h1C8, "lib pll on");
      dr(9, 64'h096);
      chk(pll_cfg[8:0] === 9'h096, "lib pll off");
      ir(SCRC_I_FAST_PLL);
      for (int v = 0; v < 4; v++) begin
         dr(2, 64'(v));
         chk(pll_cfg[10:9] === {v[0], v[1]}, "fast pll mode");
      end
      ir(SCRC_I_LINK_INIT);
      dr(1, 64'h1);
      chk(link_en === 1'b1, "link init");
      apb(1'b1, SCRC_A_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      chk(link_en === 1'b0, "link hold");
      apb(1'b0, SCRC_A_CTRL, 32'h0);
      chk(r[1:0] === 2'b11 && e === 1'b0, "ctrl read");
      apb(1'b1, 12'h010, 32'h1);
      chk(e === 1'b1, "unmapped write");
      apb(1'b0, 12'h010, 32'h0);
      chk(e === 1'b1 && r === 32'h0, "unmapped read");
      repeat (5) scrc_jtag_host_inst.tick(1'b1, 1'b0, e);
      chk(pll_cfg === 11'h564 && link_en === 1'b0, "test reset");
      scrc_jtag_host_inst.tick(1'b0, 1'b0, e);
      $display("pll test done");
   endtask
   task automatic t_arq();
      seen = 4'h0;
      ir(SCRC_I_ARQ_RST);
      fork
         dr(4, 64'hA);
         begin
            n = 0;
            while (arq === 4'h0 && n < 4000) begin
               @(posedge clk);
               n++;
            end
            seen = arq;
            @(posedge clk);
            chk(arq === 4'h0, "arq pulse width");
         end
      join
      chk(seen === 4'hA, "arq select");
      $display("arq test done");
   endtask
   task automatic t_dbg();
      ir(SCRC_I_STATUS);
      dr(32, 64'h0);
      chk(q[31:0] === status, "status scan");
      apb(1'b0, SCRC_A_STAT, 32'h0);
      chk(r === status, "status apb");
      ir(SCRC_I_PAY_RD);
      dr(64, 64'h0);
      chk(q === pay_rd, "payload read");
      ir(SCRC_I_PAY_WR);
      dr(64, 64'hFEDC_BA98_7654_3210);
      repeat (6) @(posedge clk);
      chk(tdo_oe === 1'b0, "tdo driven outside shift");
      chk(pay_valid === 1'b1 && pay_wr === 64'hFEDC_BA98_7654_3210, "payload write");
      pay_ready <= 1'b1;
      @(posedge clk);
      pay_ready <= 1'b0;
      @(posedge clk);
      chk(pay_valid === 1'b0, "payload release");
      $display("debug test done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #300000;
      fail_count++;
      $display("[ERR] %0t watchdog", $time);
      test_done();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_reset();
      t_start();
      t_pll();
      t_arq();
      t_dbg();
      test_done();
   end
endmodule
